// ==== hw/tsense_pkg.sv ====
// Shared constants, state types and bus addresses for the module thermal sensor
// and its presence-detect store. Assumes a 10 MHz system clock sampling a
// two-wire bus whose clock runs at up to 1 MHz.
package tsense_pkg;
    // Bus addresses; values are arbitrary
    localparam logic [6:0] SENSOR_ADDR = 7'h1c;
    localparam logic [6:0] STORE_ADDR = 7'h54;
    localparam logic [6:0] PROT_SET_ADDR = 7'h30;
    localparam logic [6:0] PROT_CLR_ADDR = 7'h32;
    localparam logic [6:0] PAGE0_ADDR = 7'h34;
    localparam logic [6:0] PAGE1_ADDR = 7'h35;

    // Sensor register pointers, 16-bit registers sent high byte first
    localparam logic [7:0] PTR_STATUS = 8'h00;
    localparam logic [7:0] PTR_CONFIG = 8'h01;
    localparam logic [7:0] PTR_HIGH = 8'h02;
    localparam logic [7:0] PTR_LOW = 8'h03;
    localparam logic [7:0] PTR_CRIT = 8'h04;
    localparam logic [7:0] PTR_HYST = 8'h05;
    localparam logic [7:0] PTR_TEMP = 8'h06;

    // Field positions
    localparam int CLR_EVENT_BIT = 0;
    localparam int CFG_EN_BIT = 2;

    // Temperature is signed, 1/16 degree per step
    localparam int TW = 13;
    localparam logic [TW-1:0] HIGH_RST = 13'h0500;
    localparam logic [TW-1:0] LOW_RST = 13'h0000;
    localparam logic [TW-1:0] CRIT_RST = 13'h05f0;
    localparam logic [TW-1:0] HYST_RST = 13'h0018;

    // Store layout
    localparam int STORE_BYTES = 512;
    localparam int BLOCK_BYTES = 128;
    localparam logic [8:0] PROT_LIMIT = 9'h180;
    localparam logic [8:0] RSVD_LO = 9'h100;
    localparam logic [8:0] RSVD_HI = 9'h13f;
    localparam logic [7:0] FACTORY_SEED = 8'h5a;
    localparam logic [7:0] BLANK_BYTE = 8'hff;

    // Conversion period
    localparam int CLK_MHZ = 10;
    localparam int CONV_TIME_US = 1000;
    localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
    localparam int DIV_W = 16;

    typedef enum logic [1:0] {EV_INTERRUPT, EV_COMPARATOR, EV_CRIT_ONLY} ev_mode_t;
    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_WACK, I_WDATA, I_RDATA, I_RACK} i2c_st_t;
    typedef enum logic [1:0] {TG_NONE, TG_SENSOR, TG_STORE, TG_CTRL} target_t;

    typedef struct packed {
        ev_mode_t mode;
        logic ev_en;
        logic [TW-1:0] high;
        logic [TW-1:0] low;
        logic [TW-1:0] crit;
        logic [TW-1:0] hyst;
    } sense_cfg_t;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [TW-1:0] temp;
        logic window_prev;
        logic latch;
        logic crit;
        logic event_on;
    } mon_state_t;

    typedef struct packed {
        logic [9:0] fill;
        logic busy;
        logic [7:0] rd;
    } store_state_t;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        i2c_st_t st;
        target_t tg;
        logic rw;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [1:0] bidx;
        logic [7:0] ptr;
        logic [7:0] hold;
        logic [7:0] lo_byte;
        logic half;
        logic nack;
        logic page;
        logic [7:0] off;
        logic wp;
        logic sda_oe;
        logic clr;
        logic wr_en;
        logic [8:0] wr_addr;
        logic [7:0] wr_data;
        sense_cfg_t cfg;
    } top_state_t;
endpackage : tsense_pkg

// ==== hw/thermal_monitor.sv ====
// Periodic temperature capture and event generation.
// Assumes temp_raw is a signed reading from an on-chip converter on clk.
`timescale 1ns/1ps
module thermal_monitor #(
    parameter int CONV_CYCLES = tsense_pkg::CONV_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Converter and configuration
    input wire logic [tsense_pkg::TW-1:0] temp_raw,
    input wire tsense_pkg::sense_cfg_t cfg,
    input wire logic clear_event,
    // State seen by the bus side
    output logic [tsense_pkg::TW-1:0] temp,
    output logic above_high,
    output logic below_low,
    output logic above_crit,
    output logic event_on
);
    tsense_pkg::mon_state_t q;
    tsense_pkg::mon_state_t d;
    logic tick;
    logic outside;
    logic signed [tsense_pkg::TW:0] crit_rel;

    always_comb begin
        d = q;
        tick = (q.div == tsense_pkg::DIV_W'(CONV_CYCLES - 1));
        d.div = tick ? '0 : q.div + 1'b1;
        if (tick) begin
            d.temp = temp_raw;
        end
        above_high = $signed(q.temp) > $signed(cfg.high);
        below_low = $signed(q.temp) < $signed(cfg.low);
        outside = above_high | below_low;
        // Release point sits below the limit; one extra bit keeps it from wrapping
        crit_rel = $signed({cfg.crit[tsense_pkg::TW-1], cfg.crit}) - $signed({1'b0, cfg.hyst});
        if ($signed(q.temp) > $signed(cfg.crit)) begin
            d.crit = 1'b1;
        end else if ($signed({q.temp[tsense_pkg::TW-1], q.temp}) < crit_rel) begin
            d.crit = 1'b0;
        end
        d.window_prev = outside;
        // A fresh crossing in the clear cycle still sets the latch
        if (clear_event || cfg.mode != tsense_pkg::EV_INTERRUPT) begin
            d.latch = 1'b0;
        end
        if (outside && !q.window_prev && cfg.mode == tsense_pkg::EV_INTERRUPT) begin
            d.latch = 1'b1;
        end
        case (cfg.mode)
            tsense_pkg::EV_INTERRUPT: d.event_on = q.latch | q.crit;
            tsense_pkg::EV_COMPARATOR: d.event_on = outside | q.crit;
            tsense_pkg::EV_CRIT_ONLY: d.event_on = q.crit;
            default: d.event_on = 1'b0;
        endcase
        d.event_on = d.event_on & cfg.ev_en;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign temp = q.temp;
    assign above_crit = q.crit;
    assign event_on = q.event_on;
endmodule : thermal_monitor

// ==== hw/presence_detect_store.sv ====
// Byte store behind the presence-detect target, with lower-region protection.
// Content is loaded from a fixed pattern after reset, standing in for the
// nonvolatile array; reads are registered one cycle after the address.
`timescale 1ns/1ps
module presence_detect_store #(
    parameter int BYTES = tsense_pkg::STORE_BYTES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Read port
    input wire logic [8:0] rd_addr,
    output logic [7:0] rd_data,
    // Write port
    input wire logic wr_en,
    input wire logic [8:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic wp_lower,
    output logic ready
);
    logic [7:0] mem [BYTES];
    tsense_pkg::store_state_t q;
    tsense_pkg::store_state_t d;
    logic [8:0] fill_addr;
    logic [7:0] fill_byte;
    logic wr_ok;

    always_comb begin
        d = q;
        fill_addr = q.fill[8:0];
        // Factory image below the protection limit, blank customer area above
        if (fill_addr < tsense_pkg::PROT_LIMIT) begin
            fill_byte = fill_addr[7:0] ^ tsense_pkg::FACTORY_SEED;
        end else begin
            fill_byte = tsense_pkg::BLANK_BYTE;
        end
        if (fill_addr >= tsense_pkg::RSVD_LO && fill_addr <= tsense_pkg::RSVD_HI) begin
            fill_byte = 8'h00;
        end
        if (q.busy) begin
            d.fill = q.fill + 10'h001;
            d.busy = (q.fill != 10'(BYTES - 1));
        end
        // Protected writes are dropped silently
        wr_ok = wr_en && !q.busy && !(wp_lower && wr_addr < tsense_pkg::PROT_LIMIT);
        if (rd_addr >= tsense_pkg::RSVD_LO && rd_addr <= tsense_pkg::RSVD_HI) begin
            d.rd = 8'h00;
        end else begin
            d.rd = mem[rd_addr];
        end
    end

    always_ff @(posedge clk) begin
        if (q.busy) begin
            mem[fill_addr] <= fill_byte;
        end else if (wr_ok) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{fill: 10'h000, busy: 1'b1, rd: 8'h00};
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd;
    assign ready = !q.busy;
endmodule : presence_detect_store

// ==== hw/thermal_presence_target.sv ====
// Two-wire bus target carrying a thermal sensor and a presence-detect store.
// Assumes scl and sda come from pins with external pull-ups; both are
// oversampled by clk, so the bus clock must stay well below clk/8.
`timescale 1ns/1ps
module thermal_presence_target #(
    parameter int CONV_CYCLES = tsense_pkg::CONV_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Two-wire bus, open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Event pin, open drain
    output logic event_o,
    output logic event_oe,
    // Converter input
    input wire logic [tsense_pkg::TW-1:0] temp_raw,
    // Status
    output logic wp_active,
    output logic store_ready
);
    logic [1:0] rst_sync;
    logic rst_n;
    tsense_pkg::top_state_t q;
    tsense_pkg::top_state_t d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [6:0] addr_in;
    logic [15:0] reg_word;
    logic [15:0] wr_word;
    logic [tsense_pkg::TW-1:0] temp;
    logic above_high;
    logic below_low;
    logic above_crit;
    logic event_on;
    logic [7:0] store_rd;
    logic [7:0] next_byte;

    // Reset released through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    thermal_monitor #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_monitor (
        .clk(clk),
        .rst_n(rst_n),
        .temp_raw(temp_raw),
        .cfg(q.cfg),
        .clear_event(q.clr),
        .temp(temp),
        .above_high(above_high),
        .below_low(below_low),
        .above_crit(above_crit),
        .event_on(event_on)
    );

    presence_detect_store u_store (
        .clk(clk),
        .rst_n(rst_n),
        .rd_addr({q.page, q.off}),
        .rd_data(store_rd),
        .wr_en(q.wr_en),
        .wr_addr(q.wr_addr),
        .wr_data(q.wr_data),
        .wp_lower(q.wp),
        .ready(store_ready)
    );

    function automatic logic [15:0] sext(input logic [tsense_pkg::TW-1:0] v);
        return {{(16 - tsense_pkg::TW){v[tsense_pkg::TW-1]}}, v};
    endfunction : sext

    // Register image for the sensor pointer
    always_comb begin
        case (q.ptr)
            tsense_pkg::PTR_STATUS: reg_word = {12'h000, above_crit, below_low, above_high,
                                                event_on};
            tsense_pkg::PTR_CONFIG: reg_word = {13'h0000, q.cfg.ev_en, q.cfg.mode};
            tsense_pkg::PTR_HIGH: reg_word = sext(q.cfg.high);
            tsense_pkg::PTR_LOW: reg_word = sext(q.cfg.low);
            tsense_pkg::PTR_CRIT: reg_word = sext(q.cfg.crit);
            tsense_pkg::PTR_HYST: reg_word = sext(q.cfg.hyst);
            // Flags ride in the top bits so one read gives temperature and state
            tsense_pkg::PTR_TEMP: reg_word = {above_crit, above_high, below_low, temp};
            default: reg_word = 16'h0000;
        endcase
    end

    // Byte to send next; the low sensor byte comes from the snapshot
    always_comb begin
        if (q.tg == tsense_pkg::TG_STORE) begin
            next_byte = store_rd;
        end else if (q.tg == tsense_pkg::TG_SENSOR) begin
            next_byte = q.half ? q.lo_byte : reg_word[15:8];
        end else begin
            next_byte = 8'h00;
        end
    end

    assign scl_rise = q.scl_s2 & ~q.scl_p;
    assign scl_fall = ~q.scl_s2 & q.scl_p;
    assign start_seen = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
    assign stop_seen = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
    assign addr_in = q.sh[7:1];
    assign wr_word = {q.hold, q.sh};

    always_comb begin
        d = q;
        // Two-flop synchronisers; the second stage and its one-cycle delayed copy feed logic, never the first
        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        d.scl_p = q.scl_s2;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_p = q.sda_s2;
        d.clr = 1'b0;
        d.wr_en = 1'b0;

        if (scl_rise && q.st != tsense_pkg::I_IDLE) begin
            d.cnt = q.cnt + 4'h1;
            if (q.st == tsense_pkg::I_ADDR || q.st == tsense_pkg::I_WDATA) begin
                d.sh = {q.sh[6:0], q.sda_s2};
            end
            if (q.st == tsense_pkg::I_RACK) begin
                d.nack = q.sda_s2;
            end
        end

        if (scl_fall) begin
            case (q.st)
                tsense_pkg::I_ADDR: begin
                    if (q.cnt == 4'd8) begin
                        d.rw = q.sh[0];
                        d.tg = tsense_pkg::TG_NONE;
                        // Anything not ours is left alone for other targets
                        if (addr_in == tsense_pkg::SENSOR_ADDR) begin
                            d.tg = tsense_pkg::TG_SENSOR;
                        end else if (addr_in == tsense_pkg::STORE_ADDR && store_ready) begin
                            d.tg = tsense_pkg::TG_STORE;
                        end else if (!q.sh[0]) begin
                            case (addr_in)
                                tsense_pkg::PROT_SET_ADDR: begin
                                    d.tg = tsense_pkg::TG_CTRL;
                                    d.wp = 1'b1;
                                end
                                tsense_pkg::PROT_CLR_ADDR: begin
                                    d.tg = tsense_pkg::TG_CTRL;
                                    d.wp = 1'b0;
                                end
                                tsense_pkg::PAGE0_ADDR: begin
                                    d.tg = tsense_pkg::TG_CTRL;
                                    d.page = 1'b0;
                                end
                                tsense_pkg::PAGE1_ADDR: begin
                                    d.tg = tsense_pkg::TG_CTRL;
                                    d.page = 1'b1;
                                end
                                default: d.tg = tsense_pkg::TG_NONE;
                            endcase
                        end
                        if (d.tg == tsense_pkg::TG_NONE) begin
                            d.st = tsense_pkg::I_IDLE;
                        end else begin
                            d.st = tsense_pkg::I_WACK;
                            d.sda_oe = 1'b1;
                            d.bidx = 2'd0;
                            d.half = 1'b0;
                        end
                    end
                end
                tsense_pkg::I_WACK: begin
                    d.cnt = 4'd0;
                    if (q.rw) begin
                        d.st = tsense_pkg::I_RDATA;
                        d.sh = next_byte;
                        d.sda_oe = ~next_byte[7];
                        if (q.tg == tsense_pkg::TG_SENSOR) begin
                            // Snapshot keeps both halves from one conversion
                            d.lo_byte = q.half ? q.lo_byte : reg_word[7:0];
                            d.half = ~q.half;
                        end else begin
                            d.off = q.off + 8'h01;
                        end
                    end else begin
                        d.st = tsense_pkg::I_WDATA;
                        d.sda_oe = 1'b0;
                    end
                end
                tsense_pkg::I_WDATA: begin
                    if (q.cnt == 4'd8) begin
                        d.st = tsense_pkg::I_WACK;
                        d.sda_oe = 1'b1;
                        if (q.bidx != 2'd2) begin
                            d.bidx = q.bidx + 2'd1;
                        end
                        if (q.tg == tsense_pkg::TG_STORE) begin
                            if (q.bidx == 2'd0) begin
                                d.off = q.sh;
                            end else begin
                                d.wr_en = 1'b1;
                                d.wr_addr = {q.page, q.off};
                                d.wr_data = q.sh;
                                d.off = q.off + 8'h01;
                            end
                        end else if (q.tg == tsense_pkg::TG_SENSOR) begin
                            if (q.bidx == 2'd0) begin
                                d.ptr = q.sh;
                            end else if (q.bidx == 2'd1) begin
                                d.hold = q.sh;
                            end else begin
                                d.bidx = 2'd1;
                                case (q.ptr)
                                    tsense_pkg::PTR_STATUS: begin
                                        d.clr = wr_word[tsense_pkg::CLR_EVENT_BIT];
                                    end
                                    tsense_pkg::PTR_CONFIG: begin
                                        d.cfg.ev_en = wr_word[tsense_pkg::CFG_EN_BIT];
                                        if (wr_word[1:0] != 2'b11) begin
                                            d.cfg.mode = tsense_pkg::ev_mode_t'(wr_word[1:0]);
                                        end
                                    end
                                    tsense_pkg::PTR_HIGH: d.cfg.high = wr_word[tsense_pkg::TW-1:0];
                                    tsense_pkg::PTR_LOW: d.cfg.low = wr_word[tsense_pkg::TW-1:0];
                                    tsense_pkg::PTR_CRIT: d.cfg.crit = wr_word[tsense_pkg::TW-1:0];
                                    tsense_pkg::PTR_HYST: d.cfg.hyst = wr_word[tsense_pkg::TW-1:0];
                                    default: d.clr = 1'b0;
                                endcase
                            end
                        end
                    end
                end
                tsense_pkg::I_RDATA: begin
                    if (q.cnt == 4'd8) begin
                        d.st = tsense_pkg::I_RACK;
                        d.sda_oe = 1'b0;
                    end else begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.sda_oe = ~q.sh[6];
                    end
                end
                tsense_pkg::I_RACK: begin
                    if (q.nack) begin
                        d.st = tsense_pkg::I_IDLE;
                    end else begin
                        d.st = tsense_pkg::I_RDATA;
                        d.cnt = 4'd0;
                        d.sh = next_byte;
                        d.sda_oe = ~next_byte[7];
                        if (q.tg == tsense_pkg::TG_SENSOR) begin
                            d.lo_byte = q.half ? q.lo_byte : reg_word[7:0];
                            d.half = ~q.half;
                        end else begin
                            d.off = q.off + 8'h01;
                        end
                    end
                end
                default: d.st = q.st;
            endcase
        end

        // A repeated start keeps the pointer and store offset
        if (start_seen) begin
            d.st = tsense_pkg::I_ADDR;
            d.cnt = 4'd0;
            d.sda_oe = 1'b0;
            d.half = 1'b0;
        end else if (stop_seen) begin
            d.st = tsense_pkg::I_IDLE;
            d.sda_oe = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_p <= 1'b1;
            q.cfg <= '{mode: tsense_pkg::EV_INTERRUPT, ev_en: 1'b1,
                       high: tsense_pkg::HIGH_RST, low: tsense_pkg::LOW_RST,
                       crit: tsense_pkg::CRIT_RST, hyst: tsense_pkg::HYST_RST};
        end else begin
            q <= d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = q.sda_oe;
    // Only the monitor's flop drives the event pin; the store has no path here
    assign event_o = 1'b0;
    assign event_oe = event_on;
    assign wp_active = q.wp;
endmodule : thermal_presence_target

// ==== tb/thermal_presence_target_monitor.sv ====
// Checker on the target's pins: drive, event timing, reset.
// Assumes a bind onto the target with its conversion period.
`timescale 1ns/1ps
module thermal_presence_target_monitor #(
    parameter int CONV_CYCLES = 20
) (
    // Clock, reset, bus
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Event and status
    input wire logic event_o,
    input wire logic event_oe,
    input wire logic [tsense_pkg::TW-1:0] temp_raw,
    input wire logic wp_active,
    input wire logic store_ready
);
    // Hot reading flagged within two periods plus flops
    localparam int HOT = 2 * CONV_CYCLES + 8;
    logic [15:0] hot_q;
    logic [7:0] quiet_q;
    logic scl_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hot_q <= '0;
            quiet_q <= '0;
            scl_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            hot_q <= ($signed(temp_raw) > $signed(tsense_pkg::CRIT_RST)) ? hot_q + 16'h1 : '0;
            quiet_q <= (scl_i != scl_q) ? '0 : quiet_q + {7'h0, quiet_q != 8'hff};
        end
    end
    property p_ev_open; event_oe |-> !event_o; endproperty
    a_ev_open: assert property (p_ev_open) else $error("event pin driven high");
    property p_sda_open; sda_oe |-> !sda_o; endproperty
    a_sda_open: assert property (p_sda_open) else $error("sda driven high");
    property p_hot; hot_q == 16'(HOT) |-> event_oe; endproperty
    a_hot: assert property (p_hot) else $error("no event above critical");
    property p_idle; quiet_q == 8'h28 |-> !sda_oe; endproperty
    a_idle: assert property (p_idle) else $error("sda held on idle bus");
    property p_sda_move; $changed(sda_oe) |-> quiet_q < 8'h08; endproperty
    a_sda_move: assert property (p_sda_move) else $error("sda moved off bus clock");
    property p_wp_move; $changed(wp_active) |-> quiet_q < 8'h10; endproperty
    a_wp_move: assert property (p_wp_move) else $error("protection moved alone");
    property p_load; $rose(nrst) |-> !store_ready [*8]; endproperty
    a_load: assert property (p_load) else $error("store ready before load");
    property p_ready; $rose(nrst) |-> ##[1:600] store_ready; endproperty
    a_ready: assert property (p_ready) else $error("store never ready");
    c_event: cover property ($rose(event_oe));
    c_wp: cover property ($rose(wp_active));
    c_ack: cover property ($rose(sda_oe));
endmodule : thermal_presence_target_monitor
bind thermal_presence_target thermal_presence_target_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (.*);

// ==== tb/i2c_host_model.sv ====
// Bus controller model: drives scl, pulls sda low.
// Assumes the bench resolves sda onto sda_in.
`timescale 1ns/1ps
module i2c_host_model (
    // Clock and bus
    input wire logic clk,
    input wire logic sda_in,
    output logic scl = 1'b1,
    output logic sda_low = 1'b0
);
    task automatic hp(input int n = 4);
        repeat (n) @(posedge clk);
    endtask : hp
    // Sda moves one clk after scl falls, never with it
    task automatic xbyte(input logic [8:0] w, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            hp(1);
            sda_low <= !w[i];
            hp(3);
            scl <= 1'b1;
            hp();
            r[i] = sda_in;
            scl <= 1'b0;
        end
    endtask : xbyte
    task automatic cond(input logic stp);
        hp();
        sda_low <= stp;
        hp();
        scl <= 1'b1;
        hp();
        sda_low <= !stp;
        hp();
        if (!stp) scl <= 1'b0;
    endtask : cond
endmodule : i2c_host_model

// ==== tb/thermal_presence_target_bench.sv ====
// Bench for the sensor and store bus target.
// Assumes a pull-up on sda; the host is sole controller.
`timescale 1ns/1ps
module thermal_presence_target_bench;
    localparam int CONV = 20;
    localparam logic [6:0] SA = tsense_pkg::SENSOR_ADDR;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [12:0] temp_raw = 13'h0190;
    logic scl, sda_low, sda_o, sda_oe, event_o, event_oe, wp_active, store_ready;
    wire sda = !sda_low && !(sda_oe && !sda_o);
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [8:0] r;
    logic [15:0] v;
    initial forever #50 clk = ~clk;
    i2c_host_model u_host (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
    thermal_presence_target #(.CONV_CYCLES(CONV)) u_dut (.clk(clk), .nrst(nrst), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .event_o(event_o), .event_oe(event_oe),
        .temp_raw(temp_raw), .wp_active(wp_active), .store_ready(store_ready));
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (e !== s) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask : chk
    task automatic tx(input logic [7:0] d, input logic ak = 1'b1);
        u_host.xbyte({d, 1'b1}, r);
        chk("ack", 16'(ak), 16'(!r[0]));
    endtask : tx
    task automatic ctl(input logic [6:0] a, input logic ak = 1'b1);
        u_host.cond(1'b0);
        tx({a, 1'b0}, ak);
        u_host.cond(1'b1);
    endtask : ctl
    task automatic rd16(input logic [6:0] a, input logic [7:0] p);
        u_host.cond(1'b0);
        tx({a, 1'b0});
        tx(p);
        u_host.cond(1'b0);
        tx({a, 1'b1});
        u_host.xbyte(9'h1fe, r);
        v[15:8] = r[8:1];
        u_host.xbyte(9'h1ff, r);
        v[7:0] = r[8:1];
        u_host.cond(1'b1);
    endtask : rd16
    // Sensor: pointer, high, low; store: offset, data
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d);
        u_host.cond(1'b0);
        tx({a, 1'b0});
        tx(p);
        if (a == SA) tx(d[15:8]);
        tx(d[7:0]);
        u_host.cond(1'b1);
    endtask : wr
    task automatic sto(input logic [8:0] a, input logic w, input logic [15:0] d);
        ctl(a[8] ? tsense_pkg::PAGE1_ADDR : tsense_pkg::PAGE0_ADDR);
        if (w) wr(tsense_pkg::STORE_ADDR, a[7:0], d);
        else rd16(tsense_pkg::STORE_ADDR, a[7:0]);
        if (!w) chk("store", d, v);
    endtask : sto
    task automatic heat(input logic [12:0] t, input logic ev);
        temp_raw <= t;
        repeat (3 * CONV + 4) @(posedge clk);
        chk("event", 16'(ev), 16'(event_oe));
    endtask : heat
    task automatic t_temp();
        heat(13'h0190, 1'b0);
        rd16(SA, tsense_pkg::PTR_TEMP);
        chk("temp", 16'h0190, v);
        heat(13'h1f80, 1'b1);
        rd16(SA, tsense_pkg::PTR_TEMP);
        chk("temp", 16'h3f80, v);
        heat(13'h0190, 1'b1);
        wr(SA, tsense_pkg::PTR_STATUS, 16'h0001);
        heat(13'h0190, 1'b0);
    endtask : t_temp
    task automatic t_modes();
        wr(SA, tsense_pkg::PTR_CONFIG, 16'h0005);
        heat(13'h0550, 1'b1);
        heat(13'h0190, 1'b0);
        wr(SA, tsense_pkg::PTR_CONFIG, 16'h0006);
        heat(13'h0550, 1'b0);
        heat(13'h0600, 1'b1);
        heat(13'h05e0, 1'b1);
        heat(13'h05d0, 1'b0);
    endtask : t_modes
    task automatic t_store();
        ctl(7'h48, 1'b0);
        sto(9'h13f, 1'b0, 16'h001a);
        sto(9'h1fe, 1'b0, 16'hffff);
        ctl(tsense_pkg::PROT_SET_ADDR);
        chk("wp", 16'h0001, 16'(wp_active));
        sto(9'h17f, 1'b1, 16'h0022);
        sto(9'h180, 1'b1, 16'h0033);
        sto(9'h17f, 1'b0, 16'h2533);
        ctl(tsense_pkg::PROT_CLR_ADDR);
        sto(9'h004, 1'b1, 16'h0011);
        sto(9'h13f, 1'b1, 16'h0044);
        sto(9'h004, 1'b0, 16'h115f);
        sto(9'h13f, 1'b0, 16'h001a);
    endtask : t_store
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 600 && store_ready !== 1'b1; i++) @(posedge clk);
        chk("ready", 16'h0001, 16'(store_ready));
        t_temp();
        t_modes();
        t_store();
        give_verdict();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            give_verdict();
        end
    end
endmodule : thermal_presence_target_bench
